// ===== hdl/link_ctrl_map.svh
`ifndef LINK_CTRL_MAP_SVH
`define LINK_CTRL_MAP_SVH
`define SYNC_FRAME     8'h54
`define CLOSE_DEFAULT  8'hFF
`define RETRY_LIMIT    6'h3E
`define LONG_SYNC      15'h4402
`define SHORT_SYNC_LO  15'h0222
`define SHORT_SYNC_HI  15'h0442
`define OVERHEAD_MAX   11'h578
`define BOUNDARY_BITS  14
`define PIN_IDLE       4'h7
`define OWN_ADDR_RST   7'h7D
`endif

// ===== hdl/link_ctrl_pkg.sv
package link_ctrl_pkg;
  typedef enum logic [2:0] {
    P_VIDEO     = 3'b000,
    P_ENTRY     = 3'b001,
    P_OPEN      = 3'b010,
    P_HANDSHAKE = 3'b011,
    P_SYNC      = 3'b100
  } phase_t;
  typedef enum logic [1:0] {
    I_IDLE  = 2'b00,
    I_START = 2'b01,
    I_BIT   = 2'b10,
    I_STOP  = 2'b11
  } i2c_st_t;
  typedef struct packed {
    logic       link_enable;
    logic       iface_select;
    logic [6:0] own_addr;
    logic [7:0] closing_code;
  } cfg_t;
  typedef struct packed {
    logic [23:0] start_lim;
    logic [23:0] idle_lim;
    logic [23:0] hold_lim;
  } limits_t;
endpackage

// ===== hdl/serial_link_control_channel.sv
// Behaviour
// - decode errors over threshold drop lock; no lock frame is returned
// - missing lock frame after control phase makes a long sync pattern
// - strap high: 62 failed syncs clear serialize enable, channel stays open
// - lock low while unlocked, high while locked; dropped in handshake if no lock frame returns
// - control phase holds PLL, keeps clock, freezes data and line sync
// - control phase flag high in control phase, low in video
// - programmed frame sync edge ends video and opens control phase
// - after eight open cycles frame sync may drop without closing
// - base mode: own address programs locally, others go to I2C converter
// - peripheral link enable low stops forwarding; SDA and SCL idle
// - start timer on flag rise; activity swaps to idle timer, never both
// - timers count up and close at limit; activity restarts idle timer
// - closing frame closes channel within 2 to 3 bit times; default FF
// - error frame sent only when closed by closing frame
// - entry overhead at most 1400 cycles; waits for spread center
// - converter is fast and reorders LSB-first bytes to MSB-first
// - SDA and SCL driven low only; released for local or disabled traffic
// - select 0 with enable 1 enters bypass, held until hold timer expires
// - bypass: host or peripheral activity restarts timers; base: host only
// - bypass blocks programming, I2C path and closing frame
// - expired hold timer at close returns next phase to base mode
// - UART frame: start low, eight LSB-first bits, even parity, stop high
`timescale 1ns/100ps
`include "link_ctrl_map.svh"
module serial_link_control_channel #(
  parameter int DW         = 18,
  parameter int BIT_CYCLES = 500,
  parameter int HS_WINDOW  = 64
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  frame_sync_in,
  input  wire logic                  sync_edge_rising,
  input  wire logic                  ecu_rx,
  input  wire logic                  periph_rx,
  input  wire logic                  sda_i,
  input  wire logic                  spread_centered,
  input  wire logic                  dec_err_over,
  input  wire logic                  lock_frame_in,
  input  wire logic                  remote_wake_strap,
  input  wire logic                  prate_hi,
  input  wire logic                  cfg_write,
  input  wire link_ctrl_pkg::cfg_t    cfg_in,
  input  wire logic                  enable_write,
  input  wire logic                  enable_value,
  input  wire link_ctrl_pkg::limits_t limits,
  input  wire logic [DW-1:0]         video_in,
  input  wire logic                  hsync_in,
  output logic                       ctrl_phase_flag,
  output logic                       pll_hold,
  output logic                       lock_out,
  output logic                       lock_frame_out,
  output logic                       error_frame_out,
  output logic                       long_sync_out,
  output logic                       serialize_enable_bit,
  output logic                       bypass,
  output logic                       local_wr_valid,
  output logic [7:0]                 local_wr_data,
  output logic                       sda_o,
  output logic                       sda_oe,
  output logic                       scl_o,
  output logic                       scl_oe,
  output logic                       i2c_nack,
  output logic                       parity_err,
  output logic [DW-1:0]              video_out,
  output logic                       hsync_out
);
  localparam logic [15:0] BITC      = 16'(BIT_CYCLES);
  localparam logic [15:0] HALF      = 16'(BIT_CYCLES / 2);
  localparam int          BOUND_CYC = `BOUNDARY_BITS * BIT_CYCLES;

  // ==========================================================
  // pin synchronisers
  logic [3:0] meta;
  logic [3:0] sy;
  logic [3:0] dly;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= `PIN_IDLE;
      sy   <= `PIN_IDLE;
      dly  <= `PIN_IDLE;
    end else begin
      meta <= {frame_sync_in, ecu_rx, periph_rx, sda_i};
      sy   <= meta;
      dly  <= sy;
    end
  end
  logic fs_edge;
  logic ecu_fall;
  logic periph_fall;
  assign fs_edge     = sync_edge_rising ? (sy[3] & ~dly[3]) : (~sy[3] & dly[3]);
  assign ecu_fall    = dly[2] & ~sy[2];
  assign periph_fall = dly[1] & ~sy[1];

  // ==========================================================
  // host UART receiver
  logic        rx_busy;
  logic        rx_done;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [10:0] rx_sh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_cnt  <= 16'h0000;
      rx_idx  <= 4'h0;
      rx_sh   <= 11'h7FF;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (ecu_fall) begin
          rx_busy <= 1'b1;
          rx_cnt  <= HALF;
          rx_idx  <= 4'h0;
        end
      end else if (rx_cnt == 16'h0000) begin
        rx_cnt <= BITC - 16'h0001;
        rx_sh  <= {sy[2], rx_sh[10:1]};
        if (rx_idx == 4'hA) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end else begin
          rx_idx <= rx_idx + 4'h1;
        end
      end else begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end
  logic [7:0] rx_data;
  logic       par_ok;
  logic       byte_ok;
  assign rx_data = rx_sh[8:1];
  assign par_ok  = ~(^rx_sh[9:1]);
  assign byte_ok = rx_done & rx_sh[10] & ~rx_sh[0] & par_ok;

  // ==========================================================
  // packet boundary and address routing
  logic [19:0]         idle_cnt;
  logic                boundary;
  logic [1:0]          byte_idx;
  logic                pkt_local;
  link_ctrl_pkg::cfg_t cfg;
  link_ctrl_pkg::phase_t phase;
  assign boundary = (idle_cnt == 20'(BOUND_CYC - 1)) & sy[2] & ~rx_busy;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt  <= 20'h0_0000;
      byte_idx  <= 2'h0;
      pkt_local <= 1'b0;
    end else begin
      if (rx_busy || !sy[2] || boundary) idle_cnt <= 20'h0_0000;
      else idle_cnt <= idle_cnt + 20'h0_0001;
      if (boundary) begin
        byte_idx <= 2'h0;
      end else if (byte_ok) begin
        if (byte_idx != 2'h2) byte_idx <= byte_idx + 2'h1;
        if (byte_idx == 2'h1) pkt_local <= (rx_data[7:1] == cfg.own_addr);
      end
    end
  end
  logic in_open;
  logic base_ok;
  logic addr_hit;
  logic close_hit;
  logic fwd;
  assign in_open  = (phase == link_ctrl_pkg::P_OPEN);
  assign base_ok  = in_open & ~bypass;
  assign addr_hit = (rx_data[7:1] == cfg.own_addr);
  assign close_hit = byte_ok & base_ok & (byte_idx == 2'h0) & (rx_data == cfg.closing_code);
  assign fwd      = byte_ok & base_ok & cfg.link_enable & cfg.iface_select &
                    (((byte_idx == 2'h1) & ~addr_hit) | ((byte_idx == 2'h2) & ~pkt_local));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      local_wr_valid <= 1'b0;
      local_wr_data  <= 8'h00;
    end else begin
      local_wr_valid <= byte_ok & base_ok & (byte_idx == 2'h2) & pkt_local;
      local_wr_data  <= rx_data;
    end
  end

  // ==========================================================
  // configuration and bypass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= '{link_enable: 1'b1, iface_select: 1'b1, own_addr: `OWN_ADDR_RST, closing_code: `CLOSE_DEFAULT};
    end else if (cfg_write && !bypass) begin
      cfg <= cfg_in;
    end
  end
  logic        close_now;
  logic        hold_done;
  logic [23:0] hold_cnt;
  logic        activity;
  assign activity = in_open & (ecu_fall | (bypass & periph_fall));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bypass    <= 1'b0;
      hold_cnt  <= 24'h00_0000;
      hold_done <= 1'b0;
    end else begin
      if (cfg_write && !bypass && cfg_in.link_enable && !cfg_in.iface_select) begin
        bypass    <= 1'b1;
        hold_cnt  <= 24'h00_0000;
        hold_done <= 1'b0;
      end else if (close_now && bypass && hold_done) begin
        bypass <= 1'b0;
      end else if (bypass && in_open) begin
        if (activity) begin
          hold_cnt  <= 24'h00_0000;
          hold_done <= 1'b0;
        end else if (!hold_done) begin
          hold_cnt  <= hold_cnt + 24'h00_0001;
          hold_done <= (hold_cnt + 24'h00_0001) >= limits.hold_lim;
        end
      end
    end
  end

  // ==========================================================
  // start and idle timers share one counter, so they never run together
  logic [23:0] tmr_cnt;
  logic        tmr_idle;
  logic        tmr_exp;
  assign tmr_exp   = serialize_enable_bit &
                     (tmr_cnt >= (tmr_idle ? limits.idle_lim : limits.start_lim));
  assign close_now = in_open & serialize_enable_bit & ~activity & (tmr_exp | close_hit);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_cnt  <= 24'h00_0000;
      tmr_idle <= 1'b0;
    end else if (!in_open) begin
      tmr_cnt  <= 24'h00_0000;
      tmr_idle <= 1'b0;
    end else if (activity) begin
      tmr_cnt  <= 24'h00_0000;
      tmr_idle <= 1'b1;
    end else if (!tmr_exp) begin
      tmr_cnt <= tmr_cnt + 24'h00_0001;
    end
  end

  // ==========================================================
  // phase sequencing
  logic [10:0] ovh;
  logic [14:0] pat_cnt;
  logic [15:0] hs_cnt;
  logic [5:0]  fails;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase                <= link_ctrl_pkg::P_VIDEO;
      ovh                  <= 11'h000;
      pat_cnt              <= 15'h0000;
      hs_cnt               <= 16'h0000;
      fails                <= 6'h00;
      serialize_enable_bit <= 1'b1;
      lock_frame_out       <= 1'b0;
      error_frame_out      <= 1'b0;
      long_sync_out        <= 1'b0;
    end else begin
      lock_frame_out  <= 1'b0;
      error_frame_out <= 1'b0;
      if (enable_write && !bypass) serialize_enable_bit <= enable_value;
      unique case (phase)
        link_ctrl_pkg::P_VIDEO: begin
          ovh <= 11'h000;
          if (!serialize_enable_bit) phase <= link_ctrl_pkg::P_OPEN;
          else if (fs_edge) phase <= link_ctrl_pkg::P_ENTRY;
        end
        link_ctrl_pkg::P_ENTRY: begin
          ovh <= ovh + 11'h001;
          if (spread_centered || ovh == `OVERHEAD_MAX - 11'h001) phase <= link_ctrl_pkg::P_OPEN;
        end
        link_ctrl_pkg::P_OPEN: begin
          // frame sync is not watched here, so it may drop freely
          if (close_now) begin
            phase           <= link_ctrl_pkg::P_HANDSHAKE;
            hs_cnt          <= 16'h0000;
            lock_frame_out  <= lock_out;
            error_frame_out <= close_hit;
          end
        end
        link_ctrl_pkg::P_HANDSHAKE: begin
          hs_cnt <= hs_cnt + 16'h0001;
          if (lock_frame_in) begin
            phase         <= link_ctrl_pkg::P_SYNC;
            pat_cnt       <= prate_hi ? `SHORT_SYNC_HI : `SHORT_SYNC_LO;
            long_sync_out <= 1'b0;
            fails         <= 6'h00;
          end else if (hs_cnt == 16'(HS_WINDOW - 1)) begin
            if (remote_wake_strap && fails == `RETRY_LIMIT - 6'h01) begin
              serialize_enable_bit <= 1'b0;
              fails                <= 6'h00;
              phase                <= link_ctrl_pkg::P_OPEN;
            end else begin
              fails         <= fails + 6'h01;
              phase         <= link_ctrl_pkg::P_SYNC;
              pat_cnt       <= `LONG_SYNC;
              long_sync_out <= 1'b1;
            end
          end
        end
        link_ctrl_pkg::P_SYNC: begin
          pat_cnt <= pat_cnt - 15'h0001;
          if (pat_cnt == 15'h0001) begin
            phase         <= link_ctrl_pkg::P_VIDEO;
            long_sync_out <= 1'b0;
          end
        end
        default: phase <= link_ctrl_pkg::P_VIDEO;
      endcase
    end
  end

  // ==========================================================
  // lock, flag and frozen video
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_out <= 1'b0;
    end else if (dec_err_over) begin
      lock_out <= 1'b0;
    end else if (phase == link_ctrl_pkg::P_HANDSHAKE && hs_cnt == 16'(HS_WINDOW - 1) && !lock_frame_in) begin
      lock_out <= 1'b0;
    end else if (phase == link_ctrl_pkg::P_SYNC && pat_cnt == 15'h0001) begin
      lock_out <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_phase_flag <= 1'b0;
      pll_hold        <= 1'b0;
    end else begin
      ctrl_phase_flag <= (phase != link_ctrl_pkg::P_VIDEO) && (phase != link_ctrl_pkg::P_ENTRY);
      pll_hold        <= (phase != link_ctrl_pkg::P_VIDEO);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      video_out <= '0;
      hsync_out <= 1'b0;
    end else if (phase == link_ctrl_pkg::P_VIDEO || phase == link_ctrl_pkg::P_ENTRY) begin
      video_out <= video_in;
      hsync_out <= hsync_in;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) parity_err <= 1'b0;
    // a bad frame in the entry cycle must not be lost, so set wins
    else if (rx_done && !par_ok) parity_err <= 1'b1;
    else if (phase == link_ctrl_pkg::P_ENTRY) parity_err <= 1'b0;
  end

  // ==========================================================
  // I2C master: one bit per UART bit time, SCL low in first half
  link_ctrl_pkg::i2c_st_t i2c_st;
  logic        i2c_open;
  logic [15:0] i2c_cnt;
  logic [3:0]  i2c_bits;
  logic [8:0]  i2c_sh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_st   <= link_ctrl_pkg::I_IDLE;
      i2c_open <= 1'b0;
      i2c_cnt  <= 16'h0000;
      i2c_bits <= 4'h0;
      i2c_sh   <= 9'h1FF;
      i2c_nack <= 1'b0;
    end else begin
      unique case (i2c_st)
        link_ctrl_pkg::I_IDLE: begin
          i2c_cnt <= BITC - 16'h0001;
          if (fwd) begin
            i2c_sh   <= {rx_data, 1'b1};
            i2c_bits <= 4'h8;
            i2c_st   <= i2c_open ? link_ctrl_pkg::I_BIT : link_ctrl_pkg::I_START;
            i2c_open <= 1'b1;
          end else if (i2c_open && (boundary || !cfg.link_enable)) begin
            i2c_st <= link_ctrl_pkg::I_STOP;
          end
        end
        link_ctrl_pkg::I_START: begin
          i2c_cnt <= i2c_cnt - 16'h0001;
          if (i2c_cnt == 16'h0000) begin
            i2c_cnt <= BITC - 16'h0001;
            i2c_st  <= link_ctrl_pkg::I_BIT;
          end
        end
        link_ctrl_pkg::I_BIT: begin
          i2c_cnt <= i2c_cnt - 16'h0001;
          if (i2c_cnt == 16'h0000) begin
            i2c_cnt <= BITC - 16'h0001;
            i2c_sh  <= {i2c_sh[7:0], 1'b1};
            if (i2c_bits == 4'h0) begin
              i2c_nack <= sy[0];
              i2c_st   <= link_ctrl_pkg::I_IDLE;
            end else begin
              i2c_bits <= i2c_bits - 4'h1;
            end
          end
        end
        link_ctrl_pkg::I_STOP: begin
          i2c_cnt <= i2c_cnt - 16'h0001;
          if (i2c_cnt == 16'h0000) begin
            i2c_open <= 1'b0;
            i2c_st   <= link_ctrl_pkg::I_IDLE;
          end
        end
      endcase
    end
  end
  // open drain: only ever pull low, otherwise release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      unique case (i2c_st)
        link_ctrl_pkg::I_IDLE: begin
          sda_oe <= 1'b0;
          scl_oe <= i2c_open;
        end
        link_ctrl_pkg::I_START: begin
          sda_oe <= 1'b1;
          scl_oe <= 1'b0;
        end
        link_ctrl_pkg::I_BIT: begin
          sda_oe <= ~i2c_sh[8];
          scl_oe <= (i2c_cnt >= HALF);
        end
        link_ctrl_pkg::I_STOP: begin
          sda_oe <= (i2c_cnt >= HALF);
          scl_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  video_flag_a: assert property (@(posedge clk) disable iff (rst)
    (phase == link_ctrl_pkg::P_VIDEO && $past(phase) == link_ctrl_pkg::P_VIDEO) |-> !ctrl_phase_flag)
    else $error("flag high in video");
  open_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ctrl_phase_flag) |-> ctrl_phase_flag [*8]) else $error("channel shut before eight cycles");
  entry_bound_a: assert property (@(posedge clk) disable iff (rst)
    phase == link_ctrl_pkg::P_ENTRY |-> ovh < `OVERHEAD_MAX) else $error("entry overhead too long");
  data_freeze_a: assert property (@(posedge clk) disable iff (rst)
    (in_open && $past(in_open)) |-> ($stable(video_out) && $stable(hsync_out))) else $error("video moved");
  lock_drop_a: assert property (@(posedge clk) disable iff (rst)
    dec_err_over |=> !lock_out) else $error("lock kept after errors");
  lock_frame_a: assert property (@(posedge clk) disable iff (rst)
    lock_frame_out |-> $past(lock_out)) else $error("lock frame while unlocked");
  frame_close_a: assert property (@(posedge clk) disable iff (rst)
    (close_hit && serialize_enable_bit) |=> phase == link_ctrl_pkg::P_HANDSHAKE) else $error("closing frame ignored");
  err_frame_a: assert property (@(posedge clk) disable iff (rst)
    error_frame_out |-> $past(close_hit)) else $error("error frame without closing frame");
  bypass_block_a: assert property (@(posedge clk) disable iff (rst)
    ($past(bypass) && bypass) |-> !local_wr_valid) else $error("programming in bypass");
  i2c_release_a: assert property (@(posedge clk) disable iff (rst)
    (i2c_st == link_ctrl_pkg::I_IDLE && !i2c_open) |=> (!sda_oe && !scl_oe)) else $error("bus held while idle");
endmodule

// ===== sim/far_side_model.sv
`timescale 1ns/100ps
module far_side_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sda_oe,
  input  wire logic       scl_oe,
  input  wire logic       lock_frame_out,
  input  wire logic       answer_lock,
  output logic            sda_i,
  output logic            lock_frame_in,
  output logic [7:0]      addr_seen
);
  logic       sda_q;
  logic       scl_q;
  logic       first;
  logic [3:0] cnt;
  logic [2:0] dly;
  // pull-up on the wire: released means high
  assign sda_i = !(sda_oe | (cnt == 4'h9));
  // ==========================================
  // i2c slave: acks each ninth bit, never touches scl
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_q     <= 1'b0;
      scl_q     <= 1'b0;
      first     <= 1'b0;
      cnt       <= 4'h0;
      addr_seen <= 8'h00;
    end else begin
      sda_q <= sda_oe;
      scl_q <= scl_oe;
      if (sda_oe && !sda_q && !scl_oe) begin
        cnt   <= 4'h0;
        first <= 1'b1;
      end else if (scl_oe && !scl_q) begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt == 4'h9)
          first <= 1'b0;
      end
      if (!scl_oe && scl_q && first && cnt >= 4'h1 && cnt <= 4'h8)
        addr_seen <= {addr_seen[6:0], sda_i};
    end
  end
  // ==========================================
  // lock frame answer, a few cycles late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly           <= 3'h0;
      lock_frame_in <= 1'b0;
    end else begin
      dly           <= {dly[1:0], lock_frame_out & answer_lock};
      lock_frame_in <= dly[2];
    end
  end
endmodule

// ===== sim/serial_link_control_channel_test.sv
`timescale 1ns/100ps
module serial_link_control_channel_test;
  localparam int BITC = 20;
  localparam int HSW  = 16;
  logic clk, rst, fs, ecu_rx, sda_i, spread, dec_err, lock_in, prate, cfg_wr, hs_in, ans, periph;
  logic flag, pll_hold, lock_out, lock_fo, err_fo, long_s, ser_en, bypass, wr_v;
  logic sda_o, sda_oe, scl_o, scl_oe, nack, perr, hs_out, scl_q;
  logic [7:0]             wr_d, addr_seen, last_wr, d;
  logic [17:0]            vid_in, vid_out;
  logic [18:0]            frozen;
  logic [31:0]            seed;
  link_ctrl_pkg::cfg_t    cfg;
  link_ctrl_pkg::limits_t lim;
  int                     err_total, n_tests, wr_cnt, errf_cnt, long_cnt, oe_cnt, n, w0, e0, o0;
  serial_link_control_channel #(.DW(18), .BIT_CYCLES(BITC), .HS_WINDOW(HSW)) u_serial_link_control_channel (
    .clk(clk), .rst(rst), .frame_sync_in(fs), .sync_edge_rising(1'b1), .ecu_rx(ecu_rx), .periph_rx(periph),
    .sda_i(sda_i), .spread_centered(spread), .dec_err_over(dec_err), .lock_frame_in(lock_in),
    .remote_wake_strap(1'b0), .prate_hi(prate), .cfg_write(cfg_wr), .cfg_in(cfg), .enable_write(1'b0),
    .enable_value(1'b0), .limits(lim), .video_in(vid_in), .hsync_in(hs_in), .ctrl_phase_flag(flag),
    .pll_hold(pll_hold), .lock_out(lock_out), .lock_frame_out(lock_fo), .error_frame_out(err_fo),
    .long_sync_out(long_s), .serialize_enable_bit(ser_en), .bypass(bypass), .local_wr_valid(wr_v),
    .local_wr_data(wr_d), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe), .i2c_nack(nack),
    .parity_err(perr), .video_out(vid_out), .hsync_out(hs_out));
  far_side_model u_far_side_model (
    .clk(clk), .rst(rst), .sda_oe(sda_oe), .scl_oe(scl_oe), .lock_frame_out(lock_fo), .answer_lock(ans),
    .sda_i(sda_i), .lock_frame_in(lock_in), .addr_seen(addr_seen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] addr_byte(input logic [6:0] a);
    return {a, 1'b0};
  endfunction
  // ==========================================
  // random video and event counters
  always @(posedge clk) begin
    seed <= xs(seed);
    vid_in <= seed[17:0];
    hs_in <= seed[18];
    scl_q <= scl_oe;
    if (wr_v === 1'b1) begin
      wr_cnt++;
      last_wr <= wr_d;
    end
    errf_cnt += (err_fo === 1'b1);
    long_cnt += (long_s === 1'b1);
    oe_cnt += (scl_oe === 1'b1 && scl_q === 1'b0);
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask
  task automatic send_byte(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      ecu_rx <= f[i];
      repeat (BITC) @(posedge clk);
    end
  endtask
  task automatic packet(input logic [6:0] a, input logic [7:0] b);
    send_byte(8'h54, 1'b0);
    send_byte(addr_byte(a), 1'b0);
    send_byte(b, 1'b0);
    repeat (15 * BITC) @(posedge clk);
  endtask
  task automatic open_ch();
    fs <= 1'b1;
    n = 0;
    while (flag !== 1'b1 && n < 1500) begin
      @(posedge clk);
      n++;
    end
    check("entry", 1, flag === 1'b1 && n <= 1405);
    repeat (10) @(posedge clk);
    fs <= 1'b0;
    repeat (5) @(posedge clk);
    check("flag after sync drop", 1, flag);
    check("pll hold", 1, pll_hold);
    frozen = {hs_out, vid_out};
  endtask
  task automatic wait_close();
    n = 0;
    while (flag !== 1'b0 && n < 25000) begin
      @(posedge clk);
      n++;
    end
    check("closed", 0, flag);
    check("pll released", 0, pll_hold);
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    {rst, fs, ecu_rx, spread, dec_err, prate, cfg_wr, ans, periph} = 9'h149;
    {err_total, n_tests, wr_cnt, errf_cnt, long_cnt, oe_cnt} = '0;
    seed = 32'hcca9_d821;
    cfg = '{1'b1, 1'b1, 7'h7D, 8'hFF};
    lim = '{24'h00_07D0, 24'h00_0258, 24'h00_1000};
    {vid_in, hs_in, scl_q, last_wr} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("serialize enable reset", 1, ser_en);
    check("lock reset", 0, lock_out);
    repeat (3) @(posedge clk);
    prate <= seed[0];
    // forwarded packet, idle close, unlocked handshake
    open_ch();
    packet(7'h21, seed[7:0]);
    check("i2c addr byte", addr_byte(7'h21), addr_seen);
    check("i2c activity", 1, oe_cnt > 0);
    check("i2c ack", 0, nack);
    check("frozen video", frozen, {hs_out, vid_out});
    wait_close();
    check("error frame", 0, errf_cnt);
    check("parity clean", 0, perr);
    check("long sync", 1, long_cnt > 0);
    check("lock after sync", 1, lock_out);
    // local write, closing frame, lock answered
    ans <= 1'b1;
    o0 = oe_cnt;
    e0 = long_cnt;
    d = seed[7:0];
    open_ch();
    packet(7'h7D, d);
    check("local data", d, last_wr);
    check("local writes", 1, wr_cnt);
    check("pins idle", o0, oe_cnt);
    send_byte(8'hFF, 1'b0);
    wait_close();
    check("error frame", 1, errf_cnt);
    check("no long sync", e0, long_cnt);
    check("lock held", 1, lock_out);
    // start timer close, no traffic
    open_ch();
    wait_close();
    check("start timer", 1, n + 15 >= 2000 && n <= 2000 + HSW + 1200);
    // bypass mode
    cfg.iface_select <= 1'b0;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
    check("bypass", 1, bypass);
    {w0, o0, e0} = {wr_cnt, oe_cnt, errf_cnt};
    open_ch();
    packet(7'h7D, seed[7:0]);
    send_byte(8'hFF, 1'b0);
    send_byte(8'h5A, 1'b1);
    wait_close();
    check("bypass writes", w0, wr_cnt);
    check("bypass i2c", o0, oe_cnt);
    check("bypass closing", e0, errf_cnt);
    check("parity flag", 1, perr);
    check("still bypass", 1, bypass);
    // peripheral activity keeps bypass alive; a quiet session drops it
    lim.hold_lim <= 24'h00_0400;
    spread <= 1'b1;
    open_ch();
    check("early entry", 1, n < 10);
    spread <= 1'b0;
    repeat (1000) @(posedge clk);
    periph <= 1'b0;
    repeat (3) @(posedge clk);
    periph <= 1'b1;
    wait_close();
    check("periph restart", 1, n <= 600 + HSW + 1200);
    check("bypass kept", 1, bypass);
    open_ch();
    wait_close();
    check("bypass left", 0, bypass);
    dec_err <= 1'b1;
    @(posedge clk);
    dec_err <= 1'b0;
    repeat (2) @(posedge clk);
    check("lock dropped", 0, lock_out);
    results();
  end
endmodule
